// File: logic/bpf_map.svh
/*
 * timing figures, comparator slots and timer slots of the protection block.
 * assumes a 10 MHz core clock; delays are held in microseconds.
 */
`ifndef BPF_MAP_SVH
`define BPF_MAP_SVH

// core clock period in nanoseconds
`define BPF_CLK_NS       100
`define BPF_NS_PER_US    1000

// qualification delays in microseconds
`define BPF_TOV_US       1000000
`define BPF_TOVR_US      16000
`define BPF_TUV_US       20000
`define BPF_TUVR_US      4000
`define BPF_DISCHARGE_OVERCURRENT1_DELAY_US      8000
`define BPF_SHORT_CIRCUIT_DELAY_US      250
`define BPF_DISCHARGE_OVERCURRENT_RELEASE_DELAY_US     4000
`define BPF_TOCH_US      16000
`define BPF_TOCHR_US     4000

// delay counter width
`define BPF_CNT_W        24

// comparator slots
`define BPF_NCMP         12
`define BPF_C_OV         0
`define BPF_C_OVR        1
`define BPF_C_UV         2
`define BPF_C_UVR        3
`define BPF_C_WAKE       4
`define BPF_C_OC1        5
`define BPF_C_SC         6
`define BPF_C_OCR        7
`define BPF_C_COC        8
`define BPF_C_CHGR       9
`define BPF_C_CHGDET     10
`define BPF_C_ZERO       11

// delay timer slots
`define BPF_NTMR         9
`define BPF_T_OV         0
`define BPF_T_OVR        1
`define BPF_T_UV         2
`define BPF_T_UVR        3
`define BPF_T_OC1        4
`define BPF_T_SC         5
`define BPF_T_OCR        6
`define BPF_T_COC        7
`define BPF_T_COCR       8

`endif

// File: logic/bpf_pkg.sv
/*
 * types of the protection block: the protection mode.
 * assumes nothing of its surroundings.
 */
package bpf_pkg;

   typedef enum logic [7:0]
   {
      ST_NORMAL   = 8'h01,
      ST_OVCHG    = 8'h02,
      ST_OVCHG_SC = 8'h04,
      ST_STANDBY  = 8'h08,
      ST_UVWAKE   = 8'h10,
      ST_OC1      = 8'h20,
      ST_SC       = 8'h40,
      ST_CHGOC    = 8'h80
   } bpf_mode_t;

endpackage

// File: logic/bpf_sync.sv
/*
 * three-stage synchroniser for a vector of comparator levels.
 * assumes the levels are asynchronous to core_clk; a change is taken
 * once the second and third stages agree.
 */
`timescale 1ns/1ps

module bpf_sync #(
   parameter int W = 12
) (
   // clock and reset
   input  wire logic         core_clk,
   input  wire logic         rstN,
   // levels
   input  wire logic [W-1:0] asyncIn,
   output logic      [W-1:0] syncOut
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] out;
   } bpf_sync_t;

   bpf_sync_t r;
   bpf_sync_t rNxt;

   if (W < 1) begin : g_chk
      $error("bpf_sync: W must be at least 1");
   end

   always_comb
   begin
      rNxt     = r;
      rNxt.s1  = asyncIn;
      rNxt.s2  = r.s1;
      rNxt.s3  = r.s2;
      // follow stage three only where stages two and three agree
      rNxt.out = (~(r.s2 ^ r.s3) & r.s3) | ((r.s2 ^ r.s3) & r.out);
   end

   always_ff @(posedge core_clk or negedge rstN)
   begin
      if (!rstN)
         r <= '0;
      else
         r <= rNxt;
   end

   assign syncOut = r.out;

endmodule // bpf_sync

// File: logic/bpf_delay.sv
/*
 * qualification delay: done rises once cond has held for limit cycles.
 * assumes cond is already synchronous to core_clk and limit is static.
 */
`timescale 1ns/1ps

module bpf_delay #(
   parameter int CNT_W = 24
) (
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             rstN,
   // condition and delay
   input  wire logic             cond,
   input  wire logic [CNT_W-1:0] limit,
   output logic                  done
);

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
   } bpf_delay_t;

   bpf_delay_t r;
   bpf_delay_t rNxt;

   if (CNT_W < 2 || CNT_W > 31) begin : g_chk
      $error("bpf_delay: CNT_W out of range");
   end

   always_comb
   begin
      rNxt = r;
      if (!cond)
         rNxt.cnt = '0;
      else if (r.cnt != limit)
         rNxt.cnt = r.cnt + CNT_W'(1);
   end

   always_ff @(posedge core_clk or negedge rstN)
   begin
      if (!rstN)
         r <= '0;
      else
         r <= rNxt;
   end

   assign done = cond && (r.cnt == limit);

   // ************************************************************
   // checks
   // ************************************************************
   property p_restart;
      @(posedge core_clk) disable iff (!rstN)
      !cond |=> (r.cnt == '0) && !done;
   endproperty
   a_restart: assert property (p_restart)
      else $error("delay counter kept counting after condition dropped");

   property p_done_after_hold;
      @(posedge core_clk) disable iff (!rstN)
      $rose(done) |-> cond && $past(cond) && (r.cnt == limit);
   endproperty
   a_done_after_hold: assert property (p_done_after_hold)
      else $error("delay done without a held condition");

endmodule // bpf_delay

// File: logic/bpf_fsm.sv
/*
 * mode control of a one-cell protection device: qualifies comparator
 * levels with internal delays and drives the charge and discharge
 * switches, the sense-pin pull-up and pull-down and the bias enable.
 * assumes the comparator levels come from an analog front end that is
 * asynchronous to core_clk, and that core_clk runs at 10 MHz.
 */
`timescale 1ns/1ps
`include "bpf_map.svh"

module bpf_fsm #(
   parameter int unsigned TOV_CYC   = `BPF_TOV_US   * `BPF_NS_PER_US / `BPF_CLK_NS,
   parameter int unsigned TOVR_CYC  = `BPF_TOVR_US  * `BPF_NS_PER_US / `BPF_CLK_NS,
   parameter int unsigned TUV_CYC   = `BPF_TUV_US   * `BPF_NS_PER_US / `BPF_CLK_NS,
   parameter int unsigned TUVR_CYC  = `BPF_TUVR_US  * `BPF_NS_PER_US / `BPF_CLK_NS,
   parameter int unsigned DISCHARGE_OVERCURRENT1_DELAY_CYC  = `BPF_DISCHARGE_OVERCURRENT1_DELAY_US  * `BPF_NS_PER_US / `BPF_CLK_NS,
   parameter int unsigned SHORT_CIRCUIT_DELAY_CYC  = `BPF_SHORT_CIRCUIT_DELAY_US  * `BPF_NS_PER_US / `BPF_CLK_NS,
   parameter int unsigned DISCHARGE_OVERCURRENT_RELEASE_DELAY_CYC = `BPF_DISCHARGE_OVERCURRENT_RELEASE_DELAY_US * `BPF_NS_PER_US / `BPF_CLK_NS,
   parameter int unsigned TOCH_CYC  = `BPF_TOCH_US  * `BPF_NS_PER_US / `BPF_CLK_NS,
   parameter int unsigned TOCHR_CYC = `BPF_TOCHR_US * `BPF_NS_PER_US / `BPF_CLK_NS,
   parameter int          CNT_W     = `BPF_CNT_W
) (
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       reset_n,
   // cell voltage comparators
   input  wire logic       cellAtOrAboveOvercharge,
   input  wire logic       cellBelowOverchargeRelease,
   input  wire logic       cellBelowOverdischarge,
   input  wire logic       cellAboveOverdischargeRelease,
   input  wire logic       supplyAboveAutoWakeupReleaseLevel,
   input  wire logic       cellAtZeroVolt,
   // sense pin comparators
   input  wire logic       senseAtOrAboveOvercurrent1,
   input  wire logic       senseAtOrAboveShortCircuitLevel,
   input  wire logic       senseAtOrBelowOvercurrentRelease,
   input  wire logic       senseAtOrBelowChargeOvercurrent,
   input  wire logic       senseAtOrAboveChargeRelease,
   input  wire logic       senseBelowChargerDetect,
   // power switches
   output logic            chargeSwitchOn,
   output logic            dischargeSwitchOn,
   // sense pin bias and internal bias
   output logic            sensePullupOn,
   output logic            sensePulldownOn,
   output logic            biasOn,
   // current mode, one-hot
   output logic [7:0]      modeState
);

   // ************************************************************
   // reset release and comparator synchronisation
   // ************************************************************
   logic [1:0]           rstPipe_r;
   logic                 rstN;
   logic [`BPF_NCMP-1:0] cmpAsync;
   logic [`BPF_NCMP-1:0] c;

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         rstPipe_r <= 2'h0;
      else
         rstPipe_r <= {rstPipe_r[0], 1'h1};
   end

   assign rstN = rstPipe_r[1];

   assign cmpAsync[`BPF_C_OV]     = cellAtOrAboveOvercharge;
   assign cmpAsync[`BPF_C_OVR]    = cellBelowOverchargeRelease;
   assign cmpAsync[`BPF_C_UV]     = cellBelowOverdischarge;
   assign cmpAsync[`BPF_C_UVR]    = cellAboveOverdischargeRelease;
   assign cmpAsync[`BPF_C_WAKE]   = supplyAboveAutoWakeupReleaseLevel;
   assign cmpAsync[`BPF_C_OC1]    = senseAtOrAboveOvercurrent1;
   assign cmpAsync[`BPF_C_SC]     = senseAtOrAboveShortCircuitLevel;
   assign cmpAsync[`BPF_C_OCR]    = senseAtOrBelowOvercurrentRelease;
   assign cmpAsync[`BPF_C_COC]    = senseAtOrBelowChargeOvercurrent;
   assign cmpAsync[`BPF_C_CHGR]   = senseAtOrAboveChargeRelease;
   assign cmpAsync[`BPF_C_CHGDET] = senseBelowChargerDetect;
   assign cmpAsync[`BPF_C_ZERO]   = cellAtZeroVolt;

   bpf_sync #(
      .W       (`BPF_NCMP)
   ) u_sync (
      .core_clk(core_clk),
      .rstN    (rstN),
      .asyncIn (cmpAsync),
      .syncOut (c)
   );

   // ************************************************************
   // delay timers
   // ************************************************************
   localparam int unsigned LIM [`BPF_NTMR] = '{
      TOV_CYC, TOVR_CYC, TUV_CYC, TUVR_CYC, DISCHARGE_OVERCURRENT1_DELAY_CYC,
      SHORT_CIRCUIT_DELAY_CYC, DISCHARGE_OVERCURRENT_RELEASE_DELAY_CYC, TOCH_CYC, TOCHR_CYC};

   typedef struct packed {
      bpf_pkg::bpf_mode_t mode;
      logic               chg;
      logic               dchg;
      logic               pu;
      logic               pd;
      logic               bias;
   } bpf_fsm_t;

   bpf_fsm_t             r;
   bpf_fsm_t             rNxt;
   logic [`BPF_NTMR-1:0] tmrCond;
   logic [`BPF_NTMR-1:0] done;
   logic                 chgDet;

   assign chgDet = c[`BPF_C_CHGDET];

   // conditions are gated by mode so each delay starts fresh per mode, except short circuit, which runs on from normal into over-charge
   assign tmrCond[`BPF_T_OV]   = r.mode == bpf_pkg::ST_NORMAL
                                 && c[`BPF_C_OV];
   assign tmrCond[`BPF_T_OVR]  = r.mode == bpf_pkg::ST_OVCHG
                                 && c[`BPF_C_OVR] && !chgDet;
   assign tmrCond[`BPF_T_UV]   = r.mode == bpf_pkg::ST_NORMAL
                                 && c[`BPF_C_UV];
   assign tmrCond[`BPF_T_UVR]  = r.mode == bpf_pkg::ST_UVWAKE
                                 && c[`BPF_C_UVR];
   assign tmrCond[`BPF_T_OC1]  = r.mode == bpf_pkg::ST_NORMAL
                                 && c[`BPF_C_OC1];
   assign tmrCond[`BPF_T_SC]   = (r.mode == bpf_pkg::ST_NORMAL
                                 || r.mode == bpf_pkg::ST_OVCHG)
                                 && c[`BPF_C_SC];
   assign tmrCond[`BPF_T_OCR]  = (r.mode == bpf_pkg::ST_OC1
                                 || r.mode == bpf_pkg::ST_SC)
                                 && c[`BPF_C_OCR];
   // not armed in stand-by or under-voltage wake
   assign tmrCond[`BPF_T_COC]  = r.mode == bpf_pkg::ST_NORMAL
                                 && c[`BPF_C_COC];
   // charger gone is enough to recover
   assign tmrCond[`BPF_T_COCR] = r.mode == bpf_pkg::ST_CHGOC
                                 && (c[`BPF_C_CHGR] || !chgDet);

   for (genvar i = 0; i < `BPF_NTMR; i++) begin : g_tmr
      if (LIM[i] < 1 || LIM[i] >= (1 << CNT_W)) begin : g_chk
         $error("bpf_fsm: delay count does not fit the counter");
      end
      bpf_delay #(
         .CNT_W   (CNT_W)
      ) u_delay (
         .core_clk(core_clk),
         .rstN    (rstN),
         .cond    (tmrCond[i]),
         .limit   (CNT_W'(LIM[i])),
         .done    (done[i])
      );
   end

   // ************************************************************
   // mode machine
   // ************************************************************
   always_comb
   begin
      rNxt = r;
      unique case (r.mode)
         bpf_pkg::ST_NORMAL:
         begin
            if (done[`BPF_T_SC])
               rNxt.mode = bpf_pkg::ST_SC;
            else if (done[`BPF_T_OC1])
               rNxt.mode = bpf_pkg::ST_OC1;
            else if (done[`BPF_T_UV])
               rNxt.mode = bpf_pkg::ST_STANDBY;
            else if (done[`BPF_T_OV])
               rNxt.mode = bpf_pkg::ST_OVCHG;
            else if (done[`BPF_T_COC])
               rNxt.mode = bpf_pkg::ST_CHGOC;
         end
         bpf_pkg::ST_OVCHG:
         begin
            if (done[`BPF_T_SC])
               rNxt.mode = bpf_pkg::ST_OVCHG_SC;
            else if (done[`BPF_T_OVR])
               rNxt.mode = bpf_pkg::ST_NORMAL;
         end
         bpf_pkg::ST_OVCHG_SC:
         begin
            if (!c[`BPF_C_SC])
               rNxt.mode = bpf_pkg::ST_OVCHG;
         end
         bpf_pkg::ST_STANDBY:
         begin
            if (chgDet || c[`BPF_C_WAKE])
               rNxt.mode = bpf_pkg::ST_UVWAKE;
         end
         bpf_pkg::ST_UVWAKE:
         begin
            if (done[`BPF_T_UVR])
               rNxt.mode = bpf_pkg::ST_NORMAL;
            else if (!chgDet && !c[`BPF_C_WAKE] && c[`BPF_C_UV])
               rNxt.mode = bpf_pkg::ST_STANDBY;
         end
         bpf_pkg::ST_OC1, bpf_pkg::ST_SC:
         begin
            if (done[`BPF_T_OCR])
               rNxt.mode = bpf_pkg::ST_NORMAL;
         end
         bpf_pkg::ST_CHGOC:
         begin
            if (done[`BPF_T_COCR])
               rNxt.mode = bpf_pkg::ST_NORMAL;
         end
         default:
            rNxt.mode = bpf_pkg::ST_UVWAKE;
      endcase

      // outputs follow the mode being entered
      rNxt.chg  = 1'h1;
      rNxt.dchg = 1'h1;
      rNxt.pu   = 1'h0;
      rNxt.pd   = 1'h0;
      rNxt.bias = 1'h1;
      unique case (rNxt.mode)
         bpf_pkg::ST_NORMAL:
            rNxt.chg = 1'h1;
         bpf_pkg::ST_OVCHG, bpf_pkg::ST_CHGOC:
            rNxt.chg = 1'h0;
         bpf_pkg::ST_OVCHG_SC:
         begin
            rNxt.chg  = 1'h0;
            rNxt.dchg = 1'h0;
            rNxt.pd   = 1'h1;
         end
         bpf_pkg::ST_STANDBY:
         begin
            rNxt.dchg = 1'h0;
            rNxt.pu   = 1'h1;
            rNxt.bias = 1'h0;
         end
         bpf_pkg::ST_UVWAKE:
            rNxt.dchg = chgDet && !c[`BPF_C_ZERO];
         bpf_pkg::ST_OC1, bpf_pkg::ST_SC:
         begin
            rNxt.dchg = 1'h0;
            rNxt.pd   = 1'h1;
         end
         default:
            rNxt.dchg = 1'h0;
      endcase
   end

   always_ff @(posedge core_clk or negedge rstN)
   begin
      if (!rstN)
      begin
         r.mode <= bpf_pkg::ST_UVWAKE;
         r.chg  <= 1'h1;
         r.dchg <= 1'h0;
         r.pu   <= 1'h0;
         r.pd   <= 1'h0;
         r.bias <= 1'h1;
      end
      else
         r <= rNxt;
   end

   assign chargeSwitchOn    = r.chg;
   assign dischargeSwitchOn = r.dchg;
   assign sensePullupOn     = r.pu;
   assign sensePulldownOn   = r.pd;
   assign biasOn            = r.bias;
   assign modeState         = r.mode;

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstN);

   property p_normal_on;
      r.mode == bpf_pkg::ST_NORMAL |-> r.chg && r.dchg;
   endproperty
   a_normal_on: assert property (p_normal_on)
      else $error("normal mode with a switch off");

   property p_ov_entry;
      r.mode == bpf_pkg::ST_NORMAL && done[`BPF_T_OV]
      && !done[`BPF_T_SC] && !done[`BPF_T_OC1] && !done[`BPF_T_UV]
      |=> r.mode == bpf_pkg::ST_OVCHG && !chargeSwitchOn;
   endproperty
   a_ov_entry: assert property (p_ov_entry)
      else $error("over-charge not entered");

   property p_uv_entry;
      r.mode == bpf_pkg::ST_NORMAL && done[`BPF_T_UV]
      && !done[`BPF_T_SC] && !done[`BPF_T_OC1]
      |=> !dischargeSwitchOn && sensePullupOn && !biasOn;
   endproperty
   a_uv_entry: assert property (p_uv_entry)
      else $error("over-discharge did not reach stand-by");

   property p_wake;
      r.mode == bpf_pkg::ST_STANDBY && (chgDet || c[`BPF_C_WAKE])
      |=> r.mode == bpf_pkg::ST_UVWAKE && biasOn && !sensePullupOn;
   endproperty
   a_wake: assert property (p_wake)
      else $error("stand-by not left on wake condition");

   property p_chg_det;
      r.mode == bpf_pkg::ST_UVWAKE
      |-> dischargeSwitchOn == $past(chgDet && !c[`BPF_C_ZERO]);
   endproperty
   a_chg_det: assert property (p_chg_det)
      else $error("discharge switch wrong while waking");

   property p_uv_release;
      r.mode == bpf_pkg::ST_UVWAKE && done[`BPF_T_UVR]
      |=> r.mode == bpf_pkg::ST_NORMAL ##0 dischargeSwitchOn;
   endproperty
   a_uv_release: assert property (p_uv_release)
      else $error("over-discharge release missed");

   property p_coc_off;
      r.mode inside {bpf_pkg::ST_STANDBY, bpf_pkg::ST_UVWAKE}
      |-> !done[`BPF_T_COC] && chargeSwitchOn;
   endproperty
   a_coc_off: assert property (p_coc_off)
      else $error("charge over-current active in over-discharge");

   property p_oc1;
      r.mode == bpf_pkg::ST_NORMAL && done[`BPF_T_OC1] && !done[`BPF_T_SC]
      |=> r.mode == bpf_pkg::ST_OC1 && !dischargeSwitchOn
          && sensePulldownOn;
   endproperty
   a_oc1: assert property (p_oc1)
      else $error("over-current 1 not handled");

   property p_oc_hold;
      (r.mode inside {bpf_pkg::ST_OC1, bpf_pkg::ST_SC}
       && !done[`BPF_T_OCR]) [*2] |-> !dischargeSwitchOn;
   endproperty
   a_oc_hold: assert property (p_oc_hold)
      else $error("discharge restored before release delay");

   property p_sc;
      r.mode == bpf_pkg::ST_NORMAL && done[`BPF_T_SC]
      |=> r.mode == bpf_pkg::ST_SC && sensePulldownOn ##0 !dischargeSwitchOn;
   endproperty
   a_sc: assert property (p_sc)
      else $error("short circuit not handled");

   property p_oc_release;
      r.mode == bpf_pkg::ST_SC && done[`BPF_T_OCR]
      |=> dischargeSwitchOn && !sensePulldownOn;
   endproperty
   a_oc_release: assert property (p_oc_release)
      else $error("short circuit release missed");

   property p_coc;
      r.mode == bpf_pkg::ST_NORMAL && done[`BPF_T_COC]
      && done[`BPF_T_SC:`BPF_T_UV] == '0 && !done[`BPF_T_OV]
      |=> r.mode == bpf_pkg::ST_CHGOC && !chargeSwitchOn;
   endproperty
   a_coc: assert property (p_coc)
      else $error("charge over-current not entered");

   property p_cocr;
      r.mode == bpf_pkg::ST_CHGOC && !chgDet [*2]
      ##0 done[`BPF_T_COCR] |=> chargeSwitchOn;
   endproperty
   a_cocr: assert property (p_cocr)
      else $error("charge over-current release missed");

   c_ovchg:  cover property (r.mode == bpf_pkg::ST_OVCHG);
   c_wake:   cover property (r.mode == bpf_pkg::ST_STANDBY
                             ##1 r.mode == bpf_pkg::ST_UVWAKE);
   c_oc1rel: cover property (r.mode == bpf_pkg::ST_OC1
                             ##1 r.mode == bpf_pkg::ST_NORMAL);
   c_chgoc:  cover property (r.mode == bpf_pkg::ST_CHGOC);

endmodule // bpf_fsm

// File: test/bpf_pack_model.sv
/*
 * pack model: cell level, charger and load seen as comparator levels.
 * assumes the bench steps the three levels just after core_clk rises.
 */
`timescale 1ns/1ps

module bpf_pack_model (
   // pack state: cell 0 zero 1 under 2 normal 3 over; load 1 oc 2 short
   input  wire logic [1:0] cellLvl,
   input  wire logic [1:0] loadLvl,
   input  wire logic [1:0] chgLvl,
   // comparator levels
   output logic            cellAtOrAboveOvercharge,
   output logic            cellBelowOverchargeRelease,
   output logic            cellBelowOverdischarge,
   output logic            cellAboveOverdischargeRelease,
   output logic            supplyAboveAutoWakeupReleaseLevel,
   output logic            cellAtZeroVolt,
   output logic            senseAtOrAboveOvercurrent1,
   output logic            senseAtOrAboveShortCircuitLevel,
   output logic            senseAtOrBelowOvercurrentRelease,
   output logic            senseAtOrBelowChargeOvercurrent,
   output logic            senseAtOrAboveChargeRelease,
   output logic            senseBelowChargerDetect
);
   assign cellAtZeroVolt = (cellLvl == 2'h0);
   assign cellBelowOverdischarge = (cellLvl <= 2'h1);
   assign cellAboveOverdischargeRelease = (cellLvl >= 2'h2);
   assign supplyAboveAutoWakeupReleaseLevel = (cellLvl >= 2'h2);
   assign cellAtOrAboveOvercharge = (cellLvl == 2'h3);
   assign cellBelowOverchargeRelease = (cellLvl <= 2'h2);
   assign senseAtOrAboveOvercurrent1 = (loadLvl >= 2'h1);
   assign senseAtOrAboveShortCircuitLevel = (loadLvl == 2'h2);
   // sense falls to release level only once the load is gone
   assign senseAtOrBelowOvercurrentRelease = (loadLvl == 2'h0);
   assign senseAtOrBelowChargeOvercurrent = (chgLvl == 2'h2);
   // internal current lifts sense as soon as the charger is gone
   assign senseAtOrAboveChargeRelease = (chgLvl == 2'h0);
   assign senseBelowChargerDetect = (chgLvl != 2'h0);
endmodule // bpf_pack_model

// File: test/battery_protection_fsm_test.sv
/*
 * self-checking bench of the protection mode control with a pack model.
 * assumes bpf_pkg, bpf_fsm and bpf_pack_model are compiled before it.
 */
`timescale 1ns/1ps

module battery_protection_fsm_test;
   logic       core_clk, reset_n;
   logic [1:0] cellLvl, loadLvl, chgLvl;
   logic       cellAtOrAboveOvercharge, cellBelowOverchargeRelease;
   logic       cellBelowOverdischarge, cellAboveOverdischargeRelease;
   logic       supplyAboveAutoWakeupReleaseLevel, cellAtZeroVolt;
   logic       senseAtOrAboveOvercurrent1, senseAtOrAboveShortCircuitLevel;
   logic       senseAtOrBelowOvercurrentRelease, senseBelowChargerDetect;
   logic       senseAtOrBelowChargeOvercurrent, senseAtOrAboveChargeRelease;
   logic       chargeSwitchOn, dischargeSwitchOn, biasOn;
   logic       sensePullupOn, sensePulldownOn;
   logic [7:0] modeState;
   int         failures, numChecks, cycles;

   // shortened delays in core_clk cycles, shared by the dut and the checks
   localparam int unsigned TOV = 12, TOVR = 6, TUV = 10, TUVR = 6;
   localparam int unsigned DISCHARGE_OVERCURRENT1_DELAY = 8, SHORT_CIRCUIT_DELAY = 4, DISCHARGE_OVERCURRENT_RELEASE_DELAY = 6;
   localparam int unsigned TOCH = 8, TOCHR = 6;

   bpf_pack_model pack (.cellLvl, .loadLvl, .chgLvl,
      .cellAtOrAboveOvercharge, .cellBelowOverchargeRelease,
      .cellBelowOverdischarge, .cellAboveOverdischargeRelease,
      .supplyAboveAutoWakeupReleaseLevel, .cellAtZeroVolt,
      .senseAtOrAboveOvercurrent1, .senseAtOrAboveShortCircuitLevel,
      .senseAtOrBelowOvercurrentRelease, .senseAtOrBelowChargeOvercurrent,
      .senseAtOrAboveChargeRelease, .senseBelowChargerDetect);

   bpf_fsm #(.TOV_CYC(TOV), .TOVR_CYC(TOVR), .TUV_CYC(TUV),
      .TUVR_CYC(TUVR), .DISCHARGE_OVERCURRENT1_DELAY_CYC(DISCHARGE_OVERCURRENT1_DELAY), .SHORT_CIRCUIT_DELAY_CYC(SHORT_CIRCUIT_DELAY),
      .DISCHARGE_OVERCURRENT_RELEASE_DELAY_CYC(DISCHARGE_OVERCURRENT_RELEASE_DELAY), .TOCH_CYC(TOCH),
      .TOCHR_CYC(TOCHR)) dut (.core_clk, .reset_n,
      .cellAtOrAboveOvercharge, .cellBelowOverchargeRelease,
      .cellBelowOverdischarge, .cellAboveOverdischargeRelease,
      .supplyAboveAutoWakeupReleaseLevel, .cellAtZeroVolt,
      .senseAtOrAboveOvercurrent1, .senseAtOrAboveShortCircuitLevel,
      .senseAtOrBelowOvercurrentRelease, .senseAtOrBelowChargeOvercurrent,
      .senseAtOrAboveChargeRelease, .senseBelowChargerDetect,
      .chargeSwitchOn, .dischargeSwitchOn, .sensePullupOn,
      .sensePulldownOn, .biasOn, .modeState);

   // ****************************************
   // helpers
   // ****************************************
   task automatic check(string name, logic [7:0] exp, logic [7:0] got);
      numChecks++;
      if (got !== exp)
      begin
         failures++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   // bits: charge, discharge, pull-up, pull-down, bias
   task automatic outs(logic [4:0] exp, logic [4:0] mask);
      check("outputs", {3'h0, exp & mask}, {3'h0, mask &
         {chargeSwitchOn, dischargeSwitchOn, sensePullupOn,
          sensePulldownOn, biasOn}});
   endtask

   // cyc: falling edges from the stimulus edge to the new mode, 0 = any
   task automatic waitMode(bpf_pkg::bpf_mode_t exp, int cyc);
      int n;
      n = 0;
      @(negedge core_clk);
      while (modeState !== exp && n < 60)
      begin
         @(negedge core_clk);
         n++;
      end
      check("modeState", exp, modeState);
      if (cyc > 0)
         check("cycles", 8'(cyc), 8'(n));
   endtask

   task automatic set(logic [1:0] c, logic [1:0] l, logic [1:0] g);
      @(posedge core_clk);
      cellLvl <= c;
      loadLvl <= l;
      chgLvl  <= g;
   endtask

   task automatic finish_test;
      $display("checks %0d mismatches %0d", numChecks, failures);
      if (failures == 0 && numChecks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic scStartup;
      check("modeState", bpf_pkg::ST_UVWAKE, modeState);
      outs(5'b10001, 5'h1f);
      @(posedge core_clk);
      reset_n <= 1'b1;
      waitMode(bpf_pkg::ST_NORMAL, TUVR + 7);
      outs(5'b11001, 5'h1f);
   endtask

   // two bursts, each shorter than the delay, together longer
   task automatic scGlitch;
      set(2'h2, 2'h1, 2'h0);
      repeat (DISCHARGE_OVERCURRENT1_DELAY / 2 - 1) @(posedge core_clk);
      set(2'h2, 2'h0, 2'h0);
      repeat (10) @(negedge core_clk);
      set(2'h2, 2'h1, 2'h0);
      repeat (DISCHARGE_OVERCURRENT1_DELAY - 3) @(posedge core_clk);
      set(2'h2, 2'h0, 2'h0);
      repeat (30) @(negedge core_clk);
      check("modeState", bpf_pkg::ST_NORMAL, modeState);
   endtask

   task automatic scLoadFault(logic [1:0] l, bpf_pkg::bpf_mode_t m,
                              int d);
      set(2'h2, l, 2'h0);
      waitMode(m, d + 5);
      outs(5'b00010, 5'b01110);
      set(2'h2, 2'h0, 2'h0);
      waitMode(bpf_pkg::ST_NORMAL, DISCHARGE_OVERCURRENT_RELEASE_DELAY + 5);
      outs(5'b11000, 5'b11110);
   endtask

   task automatic scChargeOc;
      set(2'h2, 2'h0, 2'h2);
      waitMode(bpf_pkg::ST_CHGOC, TOCH + 5);
      outs(5'b01000, 5'b11000);
      set(2'h2, 2'h0, 2'h0);
      waitMode(bpf_pkg::ST_NORMAL, TOCHR + 5);
      outs(5'b11000, 5'b11000);
   endtask

   task automatic scOvercharge;
      set(2'h3, 2'h0, 2'h1);
      waitMode(bpf_pkg::ST_OVCHG, TOV + 5);
      outs(5'b01000, 5'b11000);
      set(2'h3, 2'h2, 2'h1);
      waitMode(bpf_pkg::ST_OVCHG_SC, SHORT_CIRCUIT_DELAY + 5);
      outs(5'b00010, 5'b11010);
      set(2'h3, 2'h0, 2'h1);
      waitMode(bpf_pkg::ST_OVCHG, 5);
      set(2'h2, 2'h0, 2'h0);
      waitMode(bpf_pkg::ST_NORMAL, TOVR + 5);
      outs(5'b11000, 5'b11000);
   endtask

   task automatic scUnder;
      set(2'h1, 2'h0, 2'h0);
      waitMode(bpf_pkg::ST_STANDBY, TUV + 5);
      outs(5'b00100, 5'b01101);
      set(2'h2, 2'h0, 2'h0);
      waitMode(bpf_pkg::ST_UVWAKE, 5);
      outs(5'b00001, 5'b01101);
      waitMode(bpf_pkg::ST_NORMAL, TUVR);
      set(2'h1, 2'h0, 2'h0);
      waitMode(bpf_pkg::ST_STANDBY, TUV + 5);
      set(2'h1, 2'h0, 2'h1);
      waitMode(bpf_pkg::ST_UVWAKE, 5);
      outs(5'b01001, 5'b01001);
      set(2'h1, 2'h0, 2'h2);
      repeat (30) @(negedge core_clk);
      check("modeState", bpf_pkg::ST_UVWAKE, modeState);
      set(2'h0, 2'h0, 2'h1);
      repeat (10) @(negedge core_clk);
      outs(5'b00001, 5'b01001);
      set(2'h2, 2'h0, 2'h1);
      waitMode(bpf_pkg::ST_NORMAL, TUVR + 5);
      outs(5'b11001, 5'h1f);
      set(2'h2, 2'h0, 2'h0);
   endtask

   initial
   begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         failures++;
         finish_test();
      end
   end

   initial
   begin
      failures = 0;
      numChecks = 0;
      cycles = 0;
      reset_n = 1'b0;
      cellLvl = 2'h2;
      loadLvl = 2'h0;
      chgLvl = 2'h0;
      repeat (2) @(negedge core_clk);
      scStartup();
      scGlitch();
      scLoadFault(2'h1, bpf_pkg::ST_OC1, DISCHARGE_OVERCURRENT1_DELAY);
      scLoadFault(2'h2, bpf_pkg::ST_SC, SHORT_CIRCUIT_DELAY);
      scChargeOc();
      scOvercharge();
      scUnder();
      finish_test();
   end
endmodule // battery_protection_fsm_test
